// ### design/haptic_cfg_map.svh
/*
  register offsets, field positions, reset values and timing figures
  for the haptic drive mode configuration block; definitions only.
*/
`ifndef HAPTIC_CFG_MAP_SVH
`define HAPTIC_CFG_MAP_SVH
`define ADDR_DRIVE_INPUT_CONFIG   8'h1d
`define ADDR_TIMING_NVM_CONFIG    8'h1e
`define ADDR_OPEN_LOOP_PERIOD     8'h20
`define ADDR_MODE                 8'h01
`define DIC_RESET                 8'h00
`define TNC_RESET                 8'h20
`define OLP_RESET                 8'h00
`define MODE_RESET                8'h00
`define BIT_UPDATE_RATE           2
`define BIT_INPUT_ANALOG          1
`define BIT_OPEN_LOOP             0
`define BIT_ZC_HI                 7
`define BIT_ZC_LO                 6
`define BIT_CAL_HI                5
`define BIT_CAL_LO                4
`define BIT_NVM_DONE              2
`define BIT_NVM_PROGRAM           0
`define TNC_WRITE_MASK            8'hf1
`define MODE_INPUT_PIN            3'h3
`define MODE_REALTIME             3'h5
`define MODE_LIBRARY              3'h0
`define MODE_AUDIO                3'h4
`define PWM_DIVIDE                128
`define CLK_MHZ                   20
`define ZC_US_0                   100
`define ZC_US_1                   200
`define ZC_US_2                   300
`define ZC_US_3                   390
`define CAL_MS_0                  150
`define CAL_MS_1                  250
`define CAL_MS_2                  500
`define CAL_MS_3                  1000
`endif

// ### design/haptic_cfg_pkg.sv
/*
  types shared by the configuration block: drive source selection.
  assumes the map header supplies the numbers.
*/
package haptic_cfg_pkg;
  typedef enum logic [1:0] {SRC_CLOSED, SRC_PWM_DIV, SRC_PERIOD, SRC_NONE} drive_src_t;
endpackage

// ### design/pwm_divider.sv
/*
  divides rising edges of the already synchronised pwm level by a
  fixed ratio into a toggling commutation output.
  assumes pwm_sync is on clk and free of metastability.
*/
`timescale 1ns/1ns
`include "haptic_cfg_map.svh"
module pwm_divider #(
  parameter int DIV = `PWM_DIVIDE
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic enable,
  input  wire logic pwm_sync,
  output logic      commutation
);
  localparam int HALF = DIV / 2;
  logic [$clog2(DIV)-1:0] cnt_r;     // rising edges in this half period
  logic                   prev_r;    // last pwm level for edge detect
  wire                    rise = pwm_sync & ~prev_r;
  wire                    wrap = (cnt_r == ($clog2(DIV))'(HALF - 1));

  // one output period per DIV input periods, so toggle every DIV/2 edges
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r       <= '0;
      prev_r      <= 1'b0;
      commutation <= 1'b0;
    end else if (!enable) begin
      // track the level while idle, so enabling on a high pin is no edge
      cnt_r       <= '0;
      prev_r      <= pwm_sync;
      commutation <= 1'b0;
    end else begin
      prev_r <= pwm_sync;
      if (rise) begin
        cnt_r <= wrap ? '0 : cnt_r + 1'b1;
        if (wrap) commutation <= ~commutation;
      end
    end
  end
endmodule // pwm_divider

// ### design/haptic_drive_mode_config.sv
/*
  register bank steering drive mode, input pin use, zero-cross window and
  calibration duration of a resonant actuator driver.
  assumes a byte register port (addr, wr, rd, wdata) from the serial
  control bus front end on clk, and an nvm programmer that reports done.
  assumes rd and wr are one-cycle strobes from that front end.
  assumes duty_level and analog_level come from measuring logic on clk,
  so they are used without synchronising; only the pin itself is async.
  assumes the nvm programmer keeps done high once the memory is burnt,
  so the status survives a reset of this block.
  limitation: the nvm copy itself runs in the programmer; this block only
  launches it and reports its status.
*/
`timescale 1ns/1ns
`include "haptic_cfg_map.svh"
// Functional notes
// - update rate bit: once or twice per cycle
// - mode 3: input bit picks pwm or analog
// - pwm input: amplitude from measured duty
// - analog input: amplitude from pin level
// - open-loop bit: fixed frequency, else auto-resonance
// - open-loop pwm: commutation is pwm over 128
// - other play modes: frequency from period field
// - open loop with analog input not allowed
// - zero-cross window codes 100..390 us
// - calibration field defaults 2; code0 150-350ms
// - codes 1-3: 250, 500, 1000 ms minimum
// - nvm status reads 1 once programmed
// - program bit copies 0x16-0x1a, once only
// - seven-bit open loop period field
module haptic_drive_mode_config
  import haptic_cfg_pkg::*;
#(
  parameter int CAL_MAX_CYC = `CAL_MS_3 * 1000 * `CLK_MHZ
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] addr,
  input  wire logic       wr,
  input  wire logic       rd,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata,
  input  wire logic       input_trigger_pin,
  input  wire logic [7:0] duty_level,
  input  wire logic [7:0] analog_level,
  input  wire logic       nvm_done,
  output logic            nvm_start,
  output logic            amplitude_update_twice,
  output logic      [7:0] drive_amplitude,
  output logic      [1:0] drive_source,
  output logic            commutation,
  output logic      [6:0] open_loop_period,
  output logic     [15:0] zero_cross_cycles,
  output logic     [31:0] cal_min_cycles,
  output logic            config_error
);
  // window and calibration cycle counts derived from the clock rate;
  // calibration uses the minimum of each documented range, so software
  // that waits for the count never cuts settling short
  // the longest count is a parameter so a bench can shorten it
  localparam logic [15:0] ZC0 = 16'(`ZC_US_0 * `CLK_MHZ);
  localparam logic [15:0] ZC1 = 16'(`ZC_US_1 * `CLK_MHZ);
  localparam logic [15:0] ZC2 = 16'(`ZC_US_2 * `CLK_MHZ);
  localparam logic [15:0] ZC3 = 16'(`ZC_US_3 * `CLK_MHZ);
  localparam logic [31:0] CAL0 = 32'(`CAL_MS_0 * 1000 * `CLK_MHZ);
  localparam logic [31:0] CAL1 = 32'(`CAL_MS_1 * 1000 * `CLK_MHZ);
  localparam logic [31:0] CAL2 = 32'(`CAL_MS_2 * 1000 * `CLK_MHZ);
  localparam logic [31:0] CAL3 = 32'(CAL_MAX_CYC);

  // configuration storage; all of it resets to the power-on values
  // only the stored fields live here; outputs are registered copies
  logic [7:0] dic_r;          // drive_input_config
  logic [7:0] tnc_r;          // timing_and_nvm_config stored bits
  logic [6:0] olp_r;          // open loop period
  logic [2:0] mode_r;         // operating mode
  logic       nvm_used_r;     // program already launched once
  logic       nvm_done_r;     // status: nvm programmed
  logic [2:0] pin_sync_r;     // three-stage pin synchroniser

  // decode shared by read and write paths
  // kept as one function so read and write can never disagree on a hit
  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction

  // one select per mapped offset; at most one is ever high
  wire sel_dic  = hit(addr, `ADDR_DRIVE_INPUT_CONFIG);
  wire sel_tnc  = hit(addr, `ADDR_TIMING_NVM_CONFIG);
  wire sel_olp  = hit(addr, `ADDR_OPEN_LOOP_PERIOD);
  wire sel_mode = hit(addr, `ADDR_MODE);
  // fields of drive_input_config and the mode register
  wire open_loop  = dic_r[`BIT_OPEN_LOOP];
  wire analog_sel = dic_r[`BIT_INPUT_ANALOG];
  wire pin_mode   = (mode_r == `MODE_INPUT_PIN);
  // program is only honoured the first time ever; the used flag covers the
  // time before the programmer answers, the status covers later resets
  wire prog_go    = wr && sel_tnc && wdata[`BIT_NVM_PROGRAM] && !nvm_used_r &&
                    !nvm_done_r;
  // pin level settled once stages two and three agree
  // the first stage may be metastable, so it is never compared
  wire pin_stable = pin_sync_r[1] == pin_sync_r[2];
  wire [1:0] zc_code  = tnc_r[`BIT_ZC_HI:`BIT_ZC_LO];
  wire [1:0] cal_code = tnc_r[`BIT_CAL_HI:`BIT_CAL_LO];
  // the divider runs only while the pwm pin sets the commutation rate
  wire       div_on   = open_loop && pin_mode && !analog_sel;

  // read mux; unknown offsets read zero, reserved bits forced zero
  // the status bit is shown from its own flop, not from the stored byte,
  // so a write can never make it read as programmed
  wire [7:0] rd_mux =
    sel_dic  ? dic_r :
    sel_tnc  ? {tnc_r[7:4], 1'b0, nvm_done_r, 1'b0, tnc_r[0]} :
    sel_olp  ? {1'b0, olp_r} :
    sel_mode ? {5'h00, mode_r} : 8'h00;

  // drive source: open loop chooses pwm division or stored period
  // analog input has no frequency to recover, so open loop there is
  // refused and flagged rather than guessed
  wire [1:0] src_nxt =
    !open_loop              ? 2'(SRC_CLOSED) :
    pin_mode && analog_sel  ? 2'(SRC_NONE) :
    pin_mode                ? 2'(SRC_PWM_DIV) :
    2'(SRC_PERIOD);

  // amplitude follows pwm duty or analog level only in pin mode
  // outside pin mode the playback engines own the amplitude, so this is 0
  wire [7:0] amp_nxt = !pin_mode ? 8'h00 :
                       analog_sel ? analog_level :
                       duty_level;

  // window and duration codes map to fixed cycle counts; decoding here
  // keeps one table instead of one per consumer
  wire [15:0] zc_nxt  = (zc_code == 2'h0) ? ZC0 : (zc_code == 2'h1) ? ZC1 :
                        (zc_code == 2'h2) ? ZC2 : ZC3;
  wire [31:0] cal_nxt = (cal_code == 2'h0) ? CAL0 : (cal_code == 2'h1) ? CAL1 :
                        (cal_code == 2'h2) ? CAL2 : CAL3;

  // register writes; one byte per write strobe, unmapped offsets do nothing
  // reads have no side effect, so a read never disturbs a field
  always_ff @(posedge clk) begin
    if (rst) begin
      // power-on values of every field
      dic_r  <= `DIC_RESET;
      tnc_r  <= `TNC_RESET;
      olp_r  <= 7'(`OLP_RESET);
      mode_r <= 3'(`MODE_RESET);
    end else if (wr) begin
      if (sel_dic) dic_r <= wdata;
      else if (sel_tnc) tnc_r <= wdata & `TNC_WRITE_MASK;
      else if (sel_olp) olp_r <= wdata[6:0];
      else if (sel_mode) mode_r <= wdata[2:0];
    end
  end

  // nvm launch and status; done from programmer sets status for good
  // the launch is a one-cycle pulse; the programmer latches it itself
  always_ff @(posedge clk) begin
    if (rst) begin
      // reset forgets the launch; a held done input keeps it blocked
      nvm_used_r <= 1'b0;
      nvm_done_r <= 1'b0;
      nvm_start  <= 1'b0;
    end else begin
      nvm_start <= prog_go;
      if (prog_go) nvm_used_r <= 1'b1;
      if (nvm_done) nvm_done_r <= 1'b1;
    end
  end

  // pin synchroniser; the divider sees only the agreed level
  // a glitch shorter than one clock never reaches the divider
  logic pin_level_r;          // settled pin level for the divider
  always_ff @(posedge clk) begin
    if (rst) begin
      // the pin idles low, so a low start gives no false edge
      pin_sync_r  <= 3'h0;
      pin_level_r <= 1'b0;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], input_trigger_pin};
      if (pin_stable) pin_level_r <= pin_sync_r[2];
    end
  end

  // commutation for open-loop drive, recovered from the pwm pin rate;
  // the divider restarts whenever it is disabled, so a mode change never
  // leaves half a count behind
  logic comm_w;               // divider output before the output register
  pwm_divider #(.DIV(`PWM_DIVIDE)) u_div (
    .clk         (clk),
    .rst         (rst),
    .enable      (div_on),
    .pwm_sync    (pin_level_r),
    .commutation (comm_w)
  );

  // registered outputs; each is one clock behind what it follows, which
  // costs a cycle of latency but keeps every pin free of decode glitches
  always_ff @(posedge clk) begin
    if (rst) begin
      // outputs start as if the registers held their reset values
      rdata                  <= 8'h00;
      amplitude_update_twice <= 1'b0;
      drive_amplitude        <= 8'h00;
      drive_source           <= 2'(SRC_CLOSED);
      commutation            <= 1'b0;
      open_loop_period       <= 7'h00;
      zero_cross_cycles      <= ZC0;
      cal_min_cycles         <= CAL2;
      config_error           <= 1'b0;
    end else begin
      // read data stands one cycle, then drops back to zero
      rdata                  <= rd ? rd_mux : 8'h00;
      amplitude_update_twice <= dic_r[`BIT_UPDATE_RATE];
      drive_amplitude        <= amp_nxt;
      drive_source           <= src_nxt;
      commutation            <= comm_w;
      open_loop_period       <= olp_r;
      zero_cross_cycles      <= zc_nxt;
      cal_min_cycles         <= cal_nxt;
      config_error           <= open_loop && pin_mode && analog_sel;
    end
  end
endmodule // haptic_drive_mode_config

// ### bench/haptic_cfg_checker.sv
/* port checker for the drive mode config block.
   assumes the block's ports and map header; attached by bind. */
`timescale 1ns/1ns
`include "haptic_cfg_map.svh"
module haptic_cfg_checker
  import haptic_cfg_pkg::*;
#(parameter int CAL_MAX_CYC = `CAL_MS_3 * 1000 * `CLK_MHZ) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  addr,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  wdata,
  input wire logic [7:0]  rdata,
  input wire logic        nvm_start,
  input wire logic        amplitude_update_twice,
  input wire logic [1:0]  drive_source,
  input wire logic        commutation,
  input wire logic [6:0]  open_loop_period,
  input wire logic [15:0] zero_cross_cycles,
  input wire logic [31:0] cal_min_cycles,
  input wire logic        config_error
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic launched_r; // a program launch was seen since reset
  always_ff @(posedge clk) begin
    if (rst) launched_r <= 1'b0;
    else if (nvm_start) launched_r <= 1'b1;
  end
  a_rdata_idle_zero: assert property (!rd |=> rdata == 8'h00) else $error("rdata not idle zero");
  a_rate_bit_follows: assert property (wr && addr == `ADDR_DRIVE_INPUT_CONFIG |-> ##2
    amplitude_update_twice == $past(wdata[`BIT_UPDATE_RATE], 2)) else $error("rate bit wrong");
  a_period_follows: assert property (wr && addr == `ADDR_OPEN_LOOP_PERIOD |-> ##2
    open_loop_period == 7'($past(wdata, 2))) else $error("period field wrong");
  a_invalid_flagged: assert property (drive_source == 2'h3 |-> config_error)
    else $error("open loop with analog not flagged");
  a_reserved_read_zero: assert property ($past(rd) && $past(addr) == `ADDR_TIMING_NVM_CONFIG
    |-> rdata[3] == 1'b0 && rdata[1] == 1'b0) else $error("reserved bits not zero");
  a_program_once: assert property (launched_r |-> !nvm_start) else $error("second nvm launch");
  a_zc_legal: assert property (zero_cross_cycles inside {16'd2000, 16'd4000, 16'd6000,
    16'd7800}) else $error("zero cross count illegal");
  a_cal_legal: assert property (cal_min_cycles inside {32'd3000000, 32'd5000000,
    32'd10000000, CAL_MAX_CYC}) else $error("calibration count illegal");
  a_commut_pwm_only: assert property ($rose(commutation) |->
    $past(drive_source) == SRC_PWM_DIV || drive_source == SRC_PWM_DIV) else $error("stray toggle");
endmodule // haptic_cfg_checker
bind haptic_drive_mode_config haptic_cfg_checker #(.CAL_MAX_CYC(CAL_MAX_CYC)) chk_u (.clk(clk),
  .rst(rst), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata), .rdata(rdata), .nvm_start(nvm_start),
  .amplitude_update_twice(amplitude_update_twice), .drive_source(drive_source),
  .commutation(commutation), .open_loop_period(open_loop_period),
  .zero_cross_cycles(zero_cross_cycles), .cal_min_cycles(cal_min_cycles),
  .config_error(config_error));

// ### bench/drive_side_model.sv
/* far side: pwm source on the input pin and the nvm programmer.
   assumes one clock; pin idles low when the source is off. */
`timescale 1ns/1ns
module drive_side_model #(parameter int HALF = 2, parameter int NVM_LAT = 5) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pwm_en,
  input wire logic nvm_start,
  output logic     pin,
  output logic     nvm_done
);
  int ph, nl; // pwm phase and programming countdown
  // fixed pwm rate, standing for 128 times the resonance
  always_ff @(posedge clk) begin
    if (rst) begin
      pin <= 1'b0;
      ph <= 0;
      nl <= 0;
      nvm_done <= 1'b0;
    end else begin
      ph <= (ph == HALF - 1) ? 0 : ph + 1;
      pin <= pwm_en ? (ph == HALF - 1 ? !pin : pin) : 1'b0;
      if (nvm_start) nl <= NVM_LAT;
      else if (nl > 0) nl <= nl - 1;
      if (nl == 1) nvm_done <= 1'b1; // programmer reports done, level stays
    end
  end
endmodule // drive_side_model

// ### bench/tb_haptic_drive_mode_config.sv
/* self-checking bench for the drive mode config block.
   assumes map header offsets and the designer's two-cycle write effect. */
`timescale 1ns/1ns
`include "haptic_cfg_map.svh"
module tb_haptic_drive_mode_config;
  import haptic_cfg_pkg::*;
  logic        clk, rst, wr, rd, pin, nvm_done, nvm_start, pwm_en, twice, comm, cfg_err;
  logic [7:0]  addr, wdata, rdata, duty, ana, amp;
  logic [1:0]  src;
  logic [6:0]  olp;
  logic [15:0] zc;
  logic [31:0] cal;
  int          err_count, n_compared;
  haptic_drive_mode_config #(.CAL_MAX_CYC(100)) dut_u (.clk(clk), .rst(rst), .addr(addr),
    .wr(wr), .rd(rd), .wdata(wdata), .rdata(rdata), .input_trigger_pin(pin), .duty_level(duty),
    .analog_level(ana), .nvm_done(nvm_done), .nvm_start(nvm_start),
    .amplitude_update_twice(twice), .drive_amplitude(amp), .drive_source(src),
    .commutation(comm), .open_loop_period(olp), .zero_cross_cycles(zc),
    .cal_min_cycles(cal), .config_error(cfg_err));
  drive_side_model side_u (.clk(clk), .rst(rst), .pwm_en(pwm_en), .nvm_start(nvm_start),
    .pin(pin), .nvm_done(nvm_done));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n); // n edges, then settle
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
    tick(1); // effects reach the outputs one edge later
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    addr = a;
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    chk("rdata", e, rdata);
    tick(1); // let an edge pass before the next strobe
  endtask
  task automatic src_case(input logic [2:0] m, input logic [7:0] d, input logic [1:0] e);
    wreg(`ADDR_MODE, 8'(m));
    wreg(`ADDR_DRIVE_INPUT_CONFIG, d);
    chk("drive_source", e, src);
    chk("config_error", e == 2'h3, cfg_err);
  endtask
  task automatic tally_and_finish;
    if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_regs;
    int zct[4] = '{2000, 4000, 6000, 7800};
    int calt[4] = '{3000000, 5000000, 10000000, 100};
    rchk(`ADDR_TIMING_NVM_CONFIG, 8'h20);
    rchk(`ADDR_DRIVE_INPUT_CONFIG, 8'h00);
    chk("cal", 32'd10000000, cal);
    chk("zc", 32'd2000, zc);
    wreg(8'h55, 8'hff);
    rchk(8'h55, 8'h00);
    wreg(`ADDR_DRIVE_INPUT_CONFIG, 8'h04);
    chk("twice", 1, twice);
    wreg(`ADDR_OPEN_LOOP_PERIOD, 8'hff);
    chk("period", 7'h7f, olp);
    for (int i = 0; i < 4; i++) begin
      wreg(`ADDR_TIMING_NVM_CONFIG, {i[1:0], i[1:0], 4'he}); // reserved and status bits set
      chk("zc", zct[i], zc);
      chk("cal", calt[i], cal);
      rchk(`ADDR_TIMING_NVM_CONFIG, {i[1:0], i[1:0], 4'h0});
    end
  endtask
  task automatic t_modes;
    wreg(`ADDR_MODE, 8'h03);
    wreg(`ADDR_DRIVE_INPUT_CONFIG, 8'h00);
    chk("amp", duty, amp);
    wreg(`ADDR_DRIVE_INPUT_CONFIG, 8'h02);
    chk("amp", ana, amp);
    src_case(`MODE_INPUT_PIN, 8'h00, SRC_CLOSED);
    src_case(`MODE_INPUT_PIN, 8'h03, SRC_NONE);
    src_case(`MODE_REALTIME, 8'h01, SRC_PERIOD);
    src_case(`MODE_LIBRARY, 8'h01, SRC_PERIOD);
    src_case(`MODE_AUDIO, 8'h01, SRC_PERIOD);
    chk("amp", 8'h00, amp);
    src_case(`MODE_INPUT_PIN, 8'h01, SRC_PWM_DIV);
  endtask
  task automatic t_divider; // count pin rises between two commutation changes
    logic c0, p0;
    int n, k;
    pwm_en = 1'b1;
    for (int w = 0; w < 2; w++) begin
      c0 = comm;
      p0 = pin;
      n = 0;
      k = 0;
      while (comm === c0 && k < 3000) begin
        tick(1);
        k++;
        n += int'(pin && !p0);
        p0 = pin;
      end
      if (k >= 3000) begin
        err_count++;
        tally_and_finish;
      end
    end
    chk("pwm rises per half", 64, n);
    pwm_en = 1'b0;
  endtask
  task automatic t_nvm; // one launch only; status reads as programmed
    int seen;
    seen = 0;
    wreg(`ADDR_TIMING_NVM_CONFIG, 8'h21); // default calibration kept
    tick(10);
    rchk(`ADDR_TIMING_NVM_CONFIG, 8'h25);
    wreg(`ADDR_TIMING_NVM_CONFIG, 8'h20);
    addr = `ADDR_TIMING_NVM_CONFIG;
    wdata = 8'h21;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
    repeat (6) begin
      seen += int'(nvm_start === 1'b1);
      tick(1);
    end
    chk("relaunch", 0, seen);
  endtask
  initial begin
    {wr, rd, addr, wdata, pwm_en, err_count, n_compared} = '0;
    rst = 1'b1;
    duty = 8'h5a;
    ana = 8'ha5;
    tick(10);
    rst = 1'b0;
    t_regs;
    t_modes;
    t_divider;
    t_nvm;
    tally_and_finish;
  end
endmodule // tb_haptic_drive_mode_config
